/* File: pmf_pkg.sv */
// How it works
// [R1] status bit 16 shows precoding active
// [R2] auto retrain restarts training, else hold
// [R3] ctrl 2:1 comp sequence count, value+1
// [R4] ctrl 4:3 comp sequence minimum rate
// [R5] block is 66 or 130 UI
// [R6] ctrl 6:5 sets 50G comp spacing
// [R7] ctrl bit 8 forces precoding on; code forces it only while remote capability bit 1 is set
// [R8] local capability bits 0 and 1
// [R9] remote capability writable, upper bits preserved
// [R10] tx status 1:0 gives coefficient encoding
// [R11] adjustment count: 1-7 up, 9-f down
// [R12] pre-cursor ratio codes 0-3 valid
// [R13] post-cursor ratio codes 0-5 valid
// [R14] margin codes 0-6 valid
// [R15] tx status 19:18 current init mode
// [R16] equalization progress fields 21:20, 23:22
// [R17] tx control 1:0 coefficient setting mode
// [R18] auto mode coefficient controls hold zero
// [R19] tx control 19:18 init mode
// [R20] rx status flags bits 0 to 5
// [R21] rx 11:8 self-test error bin
// [R22] rx requested remote coefficients 27:12
// [R23] previous state captured before retry
// [R24] reset defaults, reserved zero or preserved
package pmf_pkg;
  localparam logic [3:0]  ADDR_STATUS     = 4'h0;
  localparam logic [3:0]  ADDR_CONTROL    = 4'h1;
  localparam logic [3:0]  ADDR_CAP        = 4'h2;
  localparam logic [3:0]  ADDR_REMOTE_CAP = 4'h3;
  localparam logic [3:0]  ADDR_TX_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_TX_CONTROL = 4'h5;
  localparam logic [3:0]  ADDR_RX_STATUS  = 4'h6;
  localparam logic [15:0] CONTROL_RESET   = 16'h004c;
  localparam logic [15:0] CONTROL_WMASK   = 16'hffff;
  localparam logic [31:0] TX_CTRL_RESET   = 32'h0000_0000;
  localparam int          PRECODE_BIT     = 16;
  localparam int          FORCE_PRE_BIT   = 8;
  localparam int          AUTO_RT_BIT     = 0;
  localparam logic [1:0]  CMODE_AUTO      = 2'h0;
  localparam logic [1:0]  CMODE_DIRECT    = 2'h1;
  localparam logic [3:0]  PRE_MAX         = 4'h3;
  localparam logic [3:0]  POST_MAX        = 4'h5;
  localparam logic [3:0]  MARGIN_MAX      = 4'h6;
  localparam logic [3:0]  SELFTEST_MAX    = 4'h8;
  localparam logic [3:0]  ST_IDLE         = 4'h0;
  localparam logic [8:0]  UI_BLOCK_66     = 9'd66;
  localparam logic [8:0]  UI_BLOCK_130    = 9'd130;
  localparam logic [11:0] BLK_RATE_0      = 12'd3200;
  localparam logic [11:0] BLK_RATE_1      = 12'd1600;
  localparam logic [11:0] BLK_RATE_2      = 12'd400;
  localparam logic [18:0] UI_50G_1        = 19'd262144;
  localparam logic [18:0] UI_50G_2        = 19'd131072;
  localparam logic [18:0] UI_50G_3        = 19'd65536;
  typedef struct packed {
    logic       signal_detect;
    logic       polarity_rev;
    logic       cdr_lock;
    logic       rx_eq_done;
    logic       symbol_align;
    logic       lane_error;
    logic [3:0] self_test_bin;
    logic [3:0] req_pre2;
    logic [3:0] req_pre1;
    logic [3:0] req_post;
    logic [3:0] req_margin;
  } pmf_rx_t;
  typedef struct packed {
    logic [1:0] status_mode;
    logic [3:0] pre2;
    logic [3:0] pre1;
    logic [3:0] post;
    logic [3:0] margin;
    logic [1:0] init_mode;
    logic [1:0] local_eq;
    logic [1:0] remote_eq;
  } pmf_tx_t;
endpackage

/* File: pmf_code_check.sv */
`timescale 1ns/1ns
module pmf_code_check
  import pmf_pkg::*;
#(
  parameter logic [3:0] MAX_CODE = 4'h3
)(
  input  wire logic [3:0] code_in,
  input  wire logic       ratio_mode_in,
  output logic [3:0]      code_out
);
  // ratio codes above max are reserved; adjustment codes 0 and 8 reserved
  always_comb
  begin
    if (ratio_mode_in)
      code_out = (code_in > MAX_CODE) ? 4'h0 : code_in; // [R12] [R13] [R14]
    else
      code_out = (code_in == 4'h0 || code_in == 4'h8) ? 4'h0 : code_in; // [R11]
  end
endmodule

/* File: pmf_cc_timer.sv */
`timescale 1ns/1ns
module pmf_cc_timer
  import pmf_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ui_tick_in,
  input  wire logic [18:0] period_in,
  output logic             due_out
);
  logic [18:0] cnt_q;
  // counts line unit intervals; zero period disables
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in || period_in == 19'd0)
    begin
      cnt_q   <= 19'd0;
      due_out <= 1'b0;
    end
    else if (ui_tick_in)
    begin
      due_out <= (cnt_q + 19'd1 >= period_in);
      cnt_q   <= (cnt_q + 19'd1 >= period_in) ? 19'd0 : cnt_q + 19'd1;
    end
    else
      due_out <= 1'b0;
  end
endmodule

/* File: pmf_phy_mgmt.sv */
`timescale 1ns/1ns
module pmf_phy_mgmt
  import pmf_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic [3:0]  phy_state_in,
  input  wire logic        train_error_in,
  input  wire logic        precode_active_in,
  input  wire logic        encoding_130_in,
  input  wire logic        ui_tick_in,
  input  wire pmf_tx_t     tx_status_in,
  input  wire pmf_rx_t     rx_status_in,
  output logic             retrain_out,
  output logic             hold_state_out,
  output logic             precode_force_out,
  output logic [2:0]       cc_count_out,
  output logic [20:0]      cc_period_ui_out,
  output logic             cc50_due_out,
  output logic             coeff_direct_out,
  output pmf_tx_t          tx_coeff_out,
  output logic [1:0]       init_mode_out
);
  localparam logic RX_PRECODE_SUPPORT = 1'b1;
  logic [15:0] control_q;
  logic [31:0] remote_cap_q;
  logic [31:0] tx_ctrl_q;
  logic        cap_rx_pre_q;
  logic [3:0]  prev_state_q;
  logic        ack_q;
  logic [31:0] rd_d;
  logic [31:0] wmask;
  logic        sel_rd;
  logic [20:0] blk_count;
  logic [20:0] blk_ui;
  logic        meta_err_q;
  logic        sync_err_q;
  logic        meta_pre_q;
  logic        sync_pre_q;
  logic [3:0]  meta_st_q;
  logic [3:0]  sync_st_q;
  logic        err_seen_q;
  logic [3:0]  st_pre2;
  logic [3:0]  st_pre1;
  logic [3:0]  st_post;
  logic [3:0]  st_marg;
  logic [3:0]  rq_pre2;
  logic [3:0]  rq_pre1;
  logic [3:0]  rq_post;
  logic [3:0]  rq_marg;
  logic [3:0]  sf_bin;
  logic        st_ratio;
  logic [18:0] cc50_period;
  logic        cc50_due;

  assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sel_rd = avs_read && !ack_q;

  // training error, precoding and state inputs come from the line side, so synchronise first
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      meta_err_q <= 1'b0;
      sync_err_q <= 1'b0;
      meta_pre_q <= 1'b0;
      sync_pre_q <= 1'b0;
      meta_st_q  <= 4'h0;
      sync_st_q  <= 4'h0;
    end
    else
    begin
      meta_err_q <= train_error_in;
      sync_err_q <= meta_err_q;
      meta_pre_q <= precode_active_in;
      sync_pre_q <= meta_pre_q;
      meta_st_q  <= phy_state_in;
      sync_st_q  <= meta_st_q;
    end
  end

  // one-cycle waitrequest: ack on the second cycle of each request
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_q           <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // never an error code, but registered like every other output
  always_ff @(posedge ref_clk_in)
  begin
    avs_response <= 2'b00;
  end

  // control register writes
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      control_q <= CONTROL_RESET; // [R24] [R3] [R6]
    else if (avs_write && ack_q && avs_address == ADDR_CONTROL)
      control_q <= (control_q & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]); // [R24]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      remote_cap_q <= 32'h0;
      cap_rx_pre_q <= RX_PRECODE_SUPPORT;
    end
    else if (avs_write && ack_q)
    begin
      if (avs_address == ADDR_REMOTE_CAP)
        remote_cap_q <= (remote_cap_q & ~wmask) | (avs_writedata & wmask); // [R9]
      if (avs_address == ADDR_CAP && avs_byteenable[0])
        cap_rx_pre_q <= avs_writedata[1]; // [R8]
    end
  end

  // coefficient fields are forced to zero while automatic exchange runs
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      tx_ctrl_q <= TX_CTRL_RESET; // [R24] [R17]
    else if (avs_write && ack_q && avs_address == ADDR_TX_CONTROL)
    begin
      tx_ctrl_q <= (tx_ctrl_q & ~wmask) | (avs_writedata & wmask);
      if (((tx_ctrl_q[1:0] & ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0])) == CMODE_AUTO)
        tx_ctrl_q[17:2] <= 16'h0; // [R18]
    end
    else if (tx_ctrl_q[1:0] == CMODE_AUTO)
      tx_ctrl_q[17:2] <= 16'h0; // [R18]
  end

  // training error handling and previous state capture
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      prev_state_q   <= ST_IDLE;
      err_seen_q     <= 1'b0;
      retrain_out    <= 1'b0;
      hold_state_out <= 1'b0;
    end
    else
    begin
      err_seen_q  <= sync_err_q;
      retrain_out <= sync_err_q && !err_seen_q && control_q[AUTO_RT_BIT]; // [R2]
      if (sync_err_q && !err_seen_q && control_q[AUTO_RT_BIT])
        prev_state_q <= sync_st_q; // [R23]
      if (control_q[AUTO_RT_BIT])
        hold_state_out <= 1'b0;
      else if (sync_err_q && !err_seen_q)
        hold_state_out <= 1'b1; // [R2]
    end
  end

  // widen before the product so the ui count is not cut to the operand width
  assign blk_ui = encoding_130_in ? {12'h0, UI_BLOCK_130} : {12'h0, UI_BLOCK_66}; // [R5]
  always_comb
  begin
    case (control_q[4:3]) // [R4]
      2'h0:    blk_count = {9'h0, BLK_RATE_0};
      2'h2:    blk_count = {9'h0, BLK_RATE_2};
      default: blk_count = {9'h0, BLK_RATE_1};
    endcase
  end

  // clock compensation settings
  always_comb
  begin
    case (control_q[6:5])
      2'h1:    cc50_period = UI_50G_1; // [R6]
      2'h2:    cc50_period = UI_50G_2;
      2'h3:    cc50_period = UI_50G_3;
      default: cc50_period = 19'd0;
    endcase
  end

  pmf_cc_timer u_cc50 (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .ui_tick_in (ui_tick_in),
    .period_in  (cc50_period),
    .due_out    (cc50_due)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      cc_count_out      <= 3'd3;
      cc_period_ui_out  <= 21'd0;
      cc50_due_out      <= 1'b0;
      precode_force_out <= 1'b0;
      coeff_direct_out  <= 1'b0;
      init_mode_out     <= 2'h0;
      tx_coeff_out      <= '0;
    end
    else
    begin
      cc_count_out <= {1'b0, control_q[2:1]} + 3'd1; // [R3]
      cc_period_ui_out <= blk_count * blk_ui; // [R4] [R5]
      cc50_due_out <= cc50_due;
      // forcing only allowed when partner advertises rx precoding
      precode_force_out <= control_q[FORCE_PRE_BIT] && remote_cap_q[1]; // [R7]
      coeff_direct_out  <= (tx_ctrl_q[1:0] == CMODE_DIRECT); // [R17]
      init_mode_out     <= tx_ctrl_q[19] ? 2'h0 : tx_ctrl_q[19:18]; // [R19]
      tx_coeff_out      <= '0;
      tx_coeff_out.pre2   <= tx_ctrl_q[5:2];
      tx_coeff_out.pre1   <= tx_ctrl_q[9:6];
      tx_coeff_out.post   <= tx_ctrl_q[13:10];
      tx_coeff_out.margin <= tx_ctrl_q[17:14];
    end
  end

  // status field sanitising: reserved codes read back as zero
  assign st_ratio = (tx_status_in.status_mode == 2'h1);
  pmf_code_check #(.MAX_CODE(PRE_MAX)) u_st_pre2 (
    .code_in (tx_status_in.pre2), .ratio_mode_in (st_ratio), .code_out (st_pre2));
  pmf_code_check #(.MAX_CODE(PRE_MAX)) u_st_pre1 (
    .code_in (tx_status_in.pre1), .ratio_mode_in (st_ratio), .code_out (st_pre1));
  pmf_code_check #(.MAX_CODE(POST_MAX)) u_st_post (
    .code_in (tx_status_in.post), .ratio_mode_in (st_ratio), .code_out (st_post));
  pmf_code_check #(.MAX_CODE(MARGIN_MAX)) u_st_marg (
    .code_in (tx_status_in.margin), .ratio_mode_in (st_ratio), .code_out (st_marg));
  pmf_code_check #(.MAX_CODE(PRE_MAX)) u_rq_pre2 (
    .code_in (rx_status_in.req_pre2), .ratio_mode_in (1'b1), .code_out (rq_pre2));
  pmf_code_check #(.MAX_CODE(PRE_MAX)) u_rq_pre1 (
    .code_in (rx_status_in.req_pre1), .ratio_mode_in (1'b1), .code_out (rq_pre1));
  pmf_code_check #(.MAX_CODE(POST_MAX)) u_rq_post (
    .code_in (rx_status_in.req_post), .ratio_mode_in (1'b1), .code_out (rq_post));
  pmf_code_check #(.MAX_CODE(MARGIN_MAX)) u_rq_marg (
    .code_in (rx_status_in.req_margin), .ratio_mode_in (1'b1), .code_out (rq_marg));
  pmf_code_check #(.MAX_CODE(SELFTEST_MAX)) u_sf_bin (
    .code_in (rx_status_in.self_test_bin), .ratio_mode_in (1'b1), .code_out (sf_bin));

  always_comb
  begin
    rd_d = 32'h0;
    case (avs_address)
      ADDR_STATUS:
      begin
        rd_d[3:0]         = sync_st_q;
        rd_d[11:8]        = prev_state_q; // [R23]
        rd_d[PRECODE_BIT] = sync_pre_q; // [R1]
      end
      ADDR_CONTROL:    rd_d[15:0] = control_q;
      ADDR_CAP:        rd_d[1:0]  = {cap_rx_pre_q, 1'b1}; // [R8]
      ADDR_REMOTE_CAP: rd_d       = remote_cap_q; // [R9]
      ADDR_TX_STATUS:
      begin
        rd_d[1:0]   = tx_status_in.status_mode[1] ? 2'h0 : tx_status_in.status_mode; // [R10]
        rd_d[5:2]   = st_pre2;
        rd_d[9:6]   = st_pre1;
        rd_d[13:10] = st_post;
        rd_d[17:14] = st_marg;
        rd_d[19:18] = tx_status_in.init_mode[1] ? 2'h0 : tx_status_in.init_mode; // [R15]
        rd_d[21:20] = tx_status_in.local_eq; // [R16]
        rd_d[23:22] = tx_status_in.remote_eq; // [R16]
      end
      ADDR_TX_CONTROL: rd_d = tx_ctrl_q;
      ADDR_RX_STATUS:
      begin
        rd_d[5:0]   = {rx_status_in.lane_error, rx_status_in.symbol_align,
                       rx_status_in.rx_eq_done, rx_status_in.cdr_lock,
                       rx_status_in.polarity_rev, rx_status_in.signal_detect}; // [R20]
        rd_d[11:8]  = sf_bin; // [R21]
        rd_d[27:12] = {rq_marg, rq_post, rq_pre1, rq_pre2}; // [R22]
      end
      default:         rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      avs_readdata <= 32'h0;
    else if (sel_rd)
      avs_readdata <= rd_d;
  end

  a_ctrl_reset: assert property (@(posedge ref_clk_in)
    $fell(reset_in) |-> control_q == CONTROL_RESET) // [R24]
    else $error("control reset value wrong");
  a_cc_count: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ##1 cc_count_out == {1'b0, $past(control_q[2:1])} + 3'd1) // [R3]
    else $error("clock comp count wrong");
  a_auto_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    tx_ctrl_q[1:0] == CMODE_AUTO && !(avs_write && ack_q) |=> tx_ctrl_q[17:2] == 16'h0) // [R18]
    else $error("coefficients not cleared in auto mode");
  a_retrain_pulse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    retrain_out |-> $past(control_q[AUTO_RT_BIT])) // [R2]
    else $error("retrain without auto enable");
  a_hold_state: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    hold_state_out |-> !control_q[AUTO_RT_BIT] || $past(control_q[AUTO_RT_BIT]) == 1'b0) // [R2]
    else $error("hold while auto retrain");
  a_precode_force: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    precode_force_out |-> $past(remote_cap_q[1]) && $past(control_q[FORCE_PRE_BIT])) // [R7]
    else $error("precoding forced without partner support");
  a_wait_one: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  a_prev_capture: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    retrain_out |-> prev_state_q == $past(sync_st_q)) // [R23]
    else $error("previous state not captured");
  a_rx_bin: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sf_bin <= SELFTEST_MAX) // [R21]
    else $error("self test bin reserved code");
  a_cc_rate: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R4] [R5]
    control_q[4:3] == 2'h2 && !encoding_130_in |=> cc_period_ui_out == 21'd26400)
    else $error("clock comp period wrong");
  a_init_reserved: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R19]
    tx_ctrl_q[19] |=> init_mode_out == 2'h0)
    else $error("reserved init mode passed on");
  a_hold_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R2]
    control_q[AUTO_RT_BIT] |=> !hold_state_out)
    else $error("hold kept while auto retrain on");
  a_cap_bit0: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R8]
    avs_read && !avs_waitrequest && avs_address == ADDR_CAP |-> avs_readdata[0])
    else $error("auto retrain support not reported");
  a_cc50_off: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R6]
    (control_q[6:5] == 2'h0) [*2] |=> !cc50_due_out)
    else $error("50g comp sequence while disabled");
  c_retrain: cover property (@(posedge ref_clk_in) disable iff (reset_in) retrain_out);
  c_hold: cover property (@(posedge ref_clk_in) disable iff (reset_in) hold_state_out);
  c_direct: cover property (@(posedge ref_clk_in) disable iff (reset_in) coeff_direct_out);
  c_cc50: cover property (@(posedge ref_clk_in) disable iff (reset_in) cc50_due_out);
endmodule

/* File: pmf_remote_phy.sv */
`timescale 1ns/1ns
module pmf_remote_phy
  import pmf_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic [3:0] state_req_in,
  input  wire logic       error_req_in,
  input  wire logic       nego_req_in,
  input  wire logic       rx_pre_ok_in,
  input  wire logic       precode_force_in,
  input  wire logic       tick_en_in,
  input  wire pmf_tx_t    tx_req_in,
  input  wire pmf_rx_t    rx_req_in,
  output logic [3:0]      phy_state_out,
  output logic            train_error_out,
  output logic            precode_active_out,
  output logic            ui_tick_out,
  output pmf_tx_t         tx_status_out,
  output pmf_rx_t         rx_status_out
);
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      phy_state_out   <= 4'h0;
      train_error_out <= 1'b0;
      ui_tick_out     <= 1'b0;
      tx_status_out   <= '0;
      rx_status_out   <= '0;
    end
    else
    begin
      phy_state_out   <= state_req_in;
      train_error_out <= error_req_in;
      ui_tick_out     <= tick_en_in;
      tx_status_out   <= tx_req_in;
      rx_status_out   <= rx_req_in;
    end
  end

  // remote receiver only honours precoding it supports, negotiated or forced
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      precode_active_out <= 1'b0;
    else
      precode_active_out <= rx_pre_ok_in & (nego_req_in | precode_force_in);
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
module tb
  import pmf_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [3:0]  st_req = 4'h0;
  logic        err_req = 1'b0;
  logic        nego_req = 1'b0;
  logic        pre_ok = 1'b0;
  logic        tick_en = 1'b0;
  logic        enc130 = 1'b0;
  pmf_tx_t     tx_req = '0;
  pmf_rx_t     rx_req = '0;
  logic [3:0]  phy_state;
  logic        train_err, pre_act, ui_tick, retrain, hold_st, pre_force, cc50, cdir;
  pmf_tx_t     tx_st, tx_coeff;
  pmf_rx_t     rx_st;
  logic [2:0]  cc_cnt;
  logic [20:0] cc_per;
  logic [1:0]  init_mode;
  logic [31:0] rd;
  int          fails = 0;
  int          tests_run = 0;
  int          n, seen;
  int          blk[3] = '{3200, 1600, 400};
  pmf_tx_t     tin[3] = '{'{1, 3, 3, 5, 6, 1, 2, 3}, '{1, 4, 15, 6, 7, 1, 1, 0},
                          '{0, 9, 7, 15, 8, 0, 3, 1}};
  pmf_tx_t     tex[3] = '{'{1, 3, 3, 5, 6, 1, 2, 3}, '{1, 0, 0, 0, 0, 1, 1, 0},
                          '{0, 9, 7, 15, 0, 0, 3, 1}};

  initial forever #25 ref_clk_in = ~ref_clk_in;

  pmf_remote_phy pmf_remote_phy_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .state_req_in(st_req), .error_req_in(err_req), .nego_req_in(nego_req),
    .rx_pre_ok_in(pre_ok), .precode_force_in(pre_force), .tick_en_in(tick_en),
    .tx_req_in(tx_req), .rx_req_in(rx_req), .phy_state_out(phy_state),
    .train_error_out(train_err), .precode_active_out(pre_act), .ui_tick_out(ui_tick),
    .tx_status_out(tx_st), .rx_status_out(rx_st));

  pmf_phy_mgmt pmf_phy_mgmt_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .phy_state_in(phy_state), .train_error_in(train_err), .precode_active_in(pre_act),
    .encoding_130_in(enc130), .ui_tick_in(ui_tick), .tx_status_in(tx_st),
    .rx_status_in(rx_st), .retrain_out(retrain), .hold_state_out(hold_st),
    .precode_force_out(pre_force), .cc_count_out(cc_cnt), .cc_period_ui_out(cc_per),
    .cc50_due_out(cc50), .coeff_direct_out(cdir), .tx_coeff_out(tx_coeff),
    .init_mode_out(init_mode));

  task automatic end_of_test;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge ref_clk_in);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 64);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk({29'h0, avs_response, avs_waitrequest}, 32'h0);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rd & m, e);
  endtask

  task automatic err_pulse;
    err_req <= 1'b1;
    tick(3);
    err_req <= 1'b0;
    seen = 0;
    repeat (20)
    begin
      @(posedge ref_clk_in);
      if (retrain === 1'b1)
        seen++;
    end
  endtask

  function automatic logic [31:0] txw(input pmf_tx_t t);
    return {8'h0, t.remote_eq, t.local_eq, t.init_mode, t.margin, t.post, t.pre1,
            t.pre2, t.status_mode};
  endfunction

  initial
  begin
    tick(5);
    reset_in <= 1'b0;
    tick(1);
    chk(cc_cnt, 3);
    rdchk(ADDR_CONTROL, 32'hffffffff, 32'h4c);
    rdchk(ADDR_TX_CONTROL, 32'hffffffff, 32'h0);
    wr(4'hf, 32'hffffffff);
    rdchk(4'hf, 32'hffffffff, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CONTROL, (i << 1) | (i << 3) | 32'h40);
      tick(2);
      chk(cc_cnt, i + 1);
      chk(cc_per, blk[i] * 66);
    end
    // preserved bits ride along; 50g spacing off
    enc130 <= 1'b1;
    wr(ADDR_CONTROL, 32'hfffffc86);
    tick(2);
    rdchk(ADDR_CONTROL, 32'hffffffff, 32'hfc86);
    chk(cc_cnt, 4);
    chk(cc_per, 3200 * 130);
    tick_en <= 1'b1;
    seen = 0;
    repeat (300)
    begin
      @(posedge ref_clk_in);
      if (cc50 === 1'b1)
        seen++;
    end
    chk(seen, 0);
    wr(ADDR_CONTROL, 32'h66);
    n = 0;
    while (cc50 !== 1'b1 && n < 65600)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    // one sequence per 65536 line ticks, plus the register stages
    chk(n >= 65536 && n <= 65540, 1);
    tick_en <= 1'b0;
    wr(ADDR_REMOTE_CAP, 32'hffffffff);
    rdchk(ADDR_REMOTE_CAP, 32'hffffffff, 32'hffffffff);
    bus(1'b1, ADDR_REMOTE_CAP, 32'h0, 4'h1);
    rdchk(ADDR_REMOTE_CAP, 32'hffffffff, 32'hffffff00);
    wr(ADDR_CAP, 32'hffffffff);
    rdchk(ADDR_CAP, 32'hffffffff, 32'h3);
    wr(ADDR_CAP, 32'h0);
    rdchk(ADDR_CAP, 32'hffffffff, 32'h1);
    // remote rx support still clear, so forcing must not take
    pre_ok <= 1'b1;
    wr(ADDR_CONTROL, 32'h14c);
    tick(2);
    chk(pre_force, 0);
    wr(ADDR_REMOTE_CAP, 32'h2);
    tick(6);
    chk(pre_force, 1);
    rdchk(ADDR_STATUS, 32'hffff0000, 32'h10000);
    wr(ADDR_CONTROL, 32'h4c);
    tick(6);
    rdchk(ADDR_STATUS, 32'hffff0000, 32'h0);
    nego_req <= 1'b1;
    tick(6);
    rdchk(ADDR_STATUS, 32'hffff0000, 32'h10000);
    for (int i = 0; i < 3; i++)
    begin
      tx_req <= tin[i];
      tick(3);
      rdchk(ADDR_TX_STATUS, 32'hffffffff, txw(tex[i]));
    end
    wr(ADDR_TX_CONTROL, 32'hfff594cc);
    tick(2);
    rdchk(ADDR_TX_CONTROL, 32'hffffffff, 32'hfff40000);
    chk({cdir, init_mode}, 3'b001);
    wr(ADDR_TX_CONTROL, 32'hfff594cd);
    tick(2);
    rdchk(ADDR_TX_CONTROL, 32'hffffffff, 32'hfff594cd);
    chk({cdir, tx_coeff.pre2, tx_coeff.post, tx_coeff.margin}, 13'h1356);
    // reserved setting mode is not direct; reserved init mode reads as initialize
    wr(ADDR_TX_CONTROL, 32'h00040002);
    tick(2);
    chk({cdir, init_mode}, 3'b001);
    wr(ADDR_TX_CONTROL, 32'h00080001);
    tick(2);
    chk({cdir, init_mode}, 3'b100);
    rx_req <= '{1, 0, 1, 0, 1, 0, 8, 3, 2, 5, 6};
    tick(3);
    rdchk(ADDR_RX_STATUS, 32'hffffffff, 32'h06523815);
    rx_req <= '{0, 1, 0, 1, 0, 1, 1, 0, 1, 0, 1};
    tick(3);
    rdchk(ADDR_RX_STATUS, 32'hffffffff, 32'h0101012a);
    rx_req <= '{0, 0, 0, 0, 0, 0, 9, 4, 15, 6, 7};
    tick(3);
    rdchk(ADDR_RX_STATUS, 32'hffffffff, 32'h0);
    wr(ADDR_CONTROL, 32'h4d);
    st_req <= 4'h5;
    tick(4);
    err_pulse();
    chk(seen, 1);
    chk(hold_st, 0);
    rdchk(ADDR_STATUS, 32'h00000f00, 32'h500);
    wr(ADDR_CONTROL, 32'h4c);
    st_req <= 4'h3;
    tick(4);
    err_pulse();
    chk(seen, 0);
    chk(hold_st, 1);
    rdchk(ADDR_STATUS, 32'h00000f0f, 32'h503);
    end_of_test();
  end

  initial
  begin
    tick(90000);
    fails++;
    end_of_test();
  end
endmodule
